/* File: core/dlis_pkg.sv */
// Purpose: shared constants and helpers for the delay line interrupt store
// Assumes: one 50 MHz clock; the line rate is a fractional enable pulse
// Notes: slot, channel and register numbering is fixed here and nowhere else
//
// Summary of operation
// - One circulation lasts 42 bit times, 81.9 us
// - Circulation splits into phase A, B, C words
// - Four 512 kHz channels interleave at 2.048 MHz
// - Channels 1-4 written at Z, W, X, Y
// - Transfers use phase B and C only
// - Real time in ch4 phase A, read in B
// - Velocity duplexed; first sensor B, partner C
// - Real time voted each circulation; velocity not
// - Real time steps 246.1 us; velocity 0.05 m/s
// - Two phase B countdowns every 492.2 us, interrupt
// - Computer loads time-to-go to start countdown
// - Ch3 phase A counts 10 circulations for converter
// - Twelve slots latched in ch1 phase C
// - Uninhibited stored bits ORed onto interrupt line
// - Computer sets acknowledge, clears stored bit
// - Source must drop and return to re-interrupt
// - Sources stay active at least 84 us
// - Ch3 phase C bits inhibit, storage kept
// - Ch1 read, ch2 write; three bits reversible
// - Handler reads storage, later resets causing bit
// - Nine external sources, three internal ones
package dlis_pkg;
	localparam int WORD_BITS = 14;
	localparam int NUM_CH = 4;
	localparam int NUM_PH = 3;
	localparam int NUM_LINES = 3;
	localparam int BIT_TIMES = NUM_PH * WORD_BITS;
	localparam int CIRC_POS = BIT_TIMES * NUM_CH;
	localparam int CLK_HZ = 50000000;
	localparam int LINE_HZ = 2048000;
	localparam int DIV_W = 26;
	localparam logic [DIV_W-1:0] DIV_STEP = DIV_W'(LINE_HZ);
	localparam logic [DIV_W-1:0] DIV_WRAP = DIV_W'(CLK_HZ - LINE_HZ);
	localparam logic [3:0] LAST_BIT = 4'(WORD_BITS - 1);
	// Times in ns; circulation counts are rounded to the nearest whole circulation
	localparam int CIRC_NS = 81900;
	localparam int RT_STEP_NS = 246100;
	localparam int CD_STEP_NS = 492200;
	localparam logic [3:0] RT_CIRCS = 4'((RT_STEP_NS + CIRC_NS / 2) / CIRC_NS);
	localparam logic [3:0] CD_CIRCS = 4'((CD_STEP_NS + CIRC_NS / 2) / CIRC_NS);
	localparam int DAC_CIRCS = 10;
	localparam logic [WORD_BITS-1:0] DAC_LAST = WORD_BITS'(DAC_CIRCS - 1);
	// Channel indices: Z, W, X, Y clock times
	localparam logic [1:0] CH_RD = 2'h0;
	localparam logic [1:0] CH_WR = 2'h1;
	localparam logic [1:0] CH_X = 2'h2;
	localparam logic [1:0] CH_Y = 2'h3;
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam logic [1:0] PH_C = 2'h2;
	// Interrupt slots
	localparam int EXT_SRC = 9;
	localparam int NUM_SLOTS = 12;
	localparam int INT_SRC = NUM_SLOTS - EXT_SRC;
	localparam int PEND_SW = 0;
	localparam int PEND_ML = 1;
	localparam int PEND_DAC = 2;
	localparam logic [WORD_BITS-1:0] REV_MASK = 14'h0007;
	localparam logic [WORD_BITS-1:0] WORD_ONE = 14'h0001;
	// Velocity sensors: 0 Z1, 1 X1, 2 Y1, 3 X2, 4 Y2, 5 Z2
	localparam int VEL_SENS = 6;
	localparam int VEL_PEND_W = 4;
	// Host register byte offsets and fields
	localparam logic [3:0] HREG_WDATA = 4'h0;
	localparam logic [3:0] HREG_CMD = 4'h4;
	localparam logic [3:0] HREG_STAT = 4'h8;
	localparam logic [3:0] HREG_RDATA = 4'hc;
	localparam int CMD_WR = 0;
	localparam int CMD_CH = 1;
	localparam int CMD_PH = 3;
	localparam int CMD_LN = 5;
	localparam int ST_BUSY = 0;
	localparam int ST_ERR = 1;
	localparam int ST_IRQ = 2;

	// Bitwise two-of-three vote
	function automatic logic [WORD_BITS-1:0] dlis_maj3(
		input logic [WORD_BITS-1:0] a,
		input logic [WORD_BITS-1:0] b,
		input logic [WORD_BITS-1:0] c);
		dlis_maj3 = (a & b) | (a & c) | (b & c);
	endfunction : dlis_maj3
endpackage : dlis_pkg

/* File: core/dlis_link_if.sv */
// Purpose: word transfer link between computer end and data adapter end
// Assumes: both ends on the same clock
// Notes: a request is held until done or err pulses
interface dlis_link_if;
	logic req;
	logic wr;
	logic [1:0] ch;
	logic [1:0] ph;
	logic [1:0] line;
	logic [13:0] wdata;
	logic done;
	logic err;
	logic [13:0] rdata;
	logic irq;
	modport dev (input req, wr, ch, ph, line, wdata, output done, err, rdata, irq);
	modport host (output req, wr, ch, ph, line, wdata, input done, err, rdata, irq);
endinterface : dlis_link_if

/* File: core/dlis_device.sv */
// Purpose: triple delay line store with interrupt, countdown and accumulation words
// Assumes: ext_irq, vel_pulse and vel_up are asynchronous pins
// Notes: each line is kept word-wise and rewritten as its word passes the tap
//
// Decided for this implementation: the strobed register port and the address map.
module dlis_device (
	input wire logic clk,
	input wire logic rstn,
	dlis_link_if.dev link,
	input wire logic [dlis_pkg::EXT_SRC-1:0] ext_irq,
	input wire logic [dlis_pkg::VEL_SENS-1:0] vel_pulse,
	input wire logic [dlis_pkg::VEL_SENS-1:0] vel_up,
	output logic dac_tick
);
	import dlis_pkg::*;

	logic [DIV_W-1:0] div_acc;
	logic line_en;
	logic [1:0] ct;
	logic [3:0] bit_ct;
	logic [1:0] ph;
	logic tap;
	logic circ_end;
	logic [WORD_BITS-1:0] dl [NUM_LINES][NUM_CH][NUM_PH];
	logic [WORD_BITS-1:0] nw [NUM_LINES];
	logic [WORD_BITS-1:0] cur_v;
	logic [WORD_BITS-1:0] st_v;
	logic [WORD_BITS-1:0] inh_v;
	logic [WORD_BITS-1:0] clr;
	logic [EXT_SRC-1:0] ext_m;
	logic [EXT_SRC-1:0] ext_s;
	logic [VEL_SENS-1:0] vp_m;
	logic [VEL_SENS-1:0] vp_s;
	logic [VEL_SENS-1:0] vp_d;
	logic [VEL_SENS-1:0] vu_m;
	logic [VEL_SENS-1:0] vu_s;
	logic signed [VEL_PEND_W-1:0] vel_pend [VEL_SENS];
	logic [INT_SRC-1:0] int_pend;
	logic [INT_SRC-1:0] next_ev;
	logic [NUM_SLOTS-1:0] src;
	logic [NUM_SLOTS-1:0] prev_src;
	logic [3:0] rt_cnt;
	logic [3:0] cd_cnt;
	logic rt_due;
	logic cd_due;
	logic [WORD_BITS-1:0] rt_latch;
	logic is_rt_rd;
	logic bad;
	logic [1:0] tgt_ph;
	logic hit;
	logic wr_hit;

	// Fractional divider: 2.048 MHz enable from 50 MHz, jitter of one clk
	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_acc <= '0;
			line_en <= 1'b0;
		end else if (div_acc >= DIV_WRAP) begin
			div_acc <= div_acc - DIV_WRAP;
			line_en <= 1'b1;
		end else begin
			div_acc <= div_acc + DIV_STEP;
			line_en <= 1'b0;
		end
	end

	// Clock time inside bit, bit inside word, word phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ct <= CH_RD;
			bit_ct <= '0;
			ph <= PH_A;
		end else if (line_en) begin
			ct <= ct + 2'h1;
			if (ct == CH_Y) begin
				if (bit_ct == LAST_BIT) begin
					bit_ct <= '0;
					ph <= (ph == PH_C) ? PH_A : ph + 2'h1;
				end else begin
					bit_ct <= bit_ct + 4'h1;
				end
			end
		end
	end

	assign tap = line_en && (bit_ct == LAST_BIT);
	assign circ_end = tap && (ph == PH_C) && (ct == CH_Y);
	assign cur_v = dlis_maj3(dl[0][ct][ph], dl[1][ct][ph], dl[2][ct][ph]);
	assign st_v = dlis_maj3(dl[0][CH_RD][PH_C], dl[1][CH_RD][PH_C], dl[2][CH_RD][PH_C]);
	assign inh_v = dlis_maj3(dl[0][CH_X][PH_C], dl[1][CH_X][PH_C], dl[2][CH_X][PH_C]);
	assign src = {int_pend, ext_s};

	// Request decode; a phase A real-time read is served at the phase B word
	assign is_rt_rd = !link.wr && (link.ch == CH_Y) && (link.ph == PH_A);
	assign tgt_ph = is_rt_rd ? PH_B : link.ph;
	assign bad = (link.ph == PH_A && !is_rt_rd) || (link.ph > PH_C)
		|| (link.wr && link.ch == CH_Y) || (link.line >= 2'(NUM_LINES));
	assign hit = tap && link.req && !bad && (link.ch == ct) && (tgt_ph == ph);
	assign wr_hit = hit && link.wr;

	// Next value of the word passing the tap, for every line
	always_comb begin
		clr = '0;
		next_ev = '0;
		for (int l = 0; l < NUM_LINES; l++) begin
			nw[l] = cur_v;
		end
		case (ct)
			CH_RD: begin
				if (ph == PH_C) begin
					if (wr_hit) begin
						clr = link.wdata;
					end
					for (int l = 0; l < NUM_LINES; l++) begin
						// New edges win over a clear in the same pass
						nw[l] = (cur_v & ~clr) | WORD_BITS'(src & ~prev_src);
					end
				end else if (wr_hit) begin
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = link.wdata & REV_MASK;
					end
				end
			end
			CH_WR, CH_X: begin
				if (ph == PH_A && ct == CH_X) begin
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = (cur_v >= DAC_LAST) ? '0 : cur_v + WORD_ONE;
					end
					next_ev[PEND_DAC] = (cur_v >= DAC_LAST);
				end else if (wr_hit) begin
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = link.wdata;
					end
				end else if (ph == PH_B && cd_due && cur_v != '0) begin
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = cur_v - WORD_ONE;
					end
					// Counter parks at zero until reloaded
					next_ev[(ct == CH_X) ? PEND_ML : PEND_SW] = (cur_v == WORD_ONE);
				end
			end
			CH_Y: begin
				if (ph == PH_A) begin
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = rt_due ? cur_v + WORD_ONE : cur_v;
					end
				end else begin
					// Duplexed words are never voted
					for (int l = 0; l < NUM_LINES; l++) begin
						nw[l] = dl[l][ct][ph]
							+ WORD_BITS'(vel_pend[(ph == PH_B) ? l : l + NUM_LINES]);
					end
				end
			end
			default: begin
				clr = '0;
			end
		endcase
	end

	// Circulating store, rewritten at the tap
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int l = 0; l < NUM_LINES; l++) begin
				for (int c = 0; c < NUM_CH; c++) begin
					for (int p = 0; p < NUM_PH; p++) begin
						dl[l][c][p] <= '0;
					end
				end
			end
		end else if (tap) begin
			for (int l = 0; l < NUM_LINES; l++) begin
				dl[l][ct][ph] <= nw[l];
			end
		end
	end

	// Circulation dividers for real-time and countdown steps
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rt_cnt <= '0;
			cd_cnt <= '0;
			rt_due <= 1'b0;
			cd_due <= 1'b0;
		end else begin
			if (circ_end) begin
				rt_cnt <= (rt_cnt == RT_CIRCS - 4'h1) ? '0 : rt_cnt + 4'h1;
				cd_cnt <= (cd_cnt == CD_CIRCS - 4'h1) ? '0 : cd_cnt + 4'h1;
			end
			if (circ_end && rt_cnt == RT_CIRCS - 4'h1) begin
				rt_due <= 1'b1;
			end else if (tap && ct == CH_Y && ph == PH_A) begin
				rt_due <= 1'b0;
			end
			if (circ_end && cd_cnt == CD_CIRCS - 4'h1) begin
				cd_due <= 1'b1;
			end else if (tap && ct == CH_X && ph == PH_B) begin
				cd_due <= 1'b0;
			end
		end
	end

	// Internal events wait for the storage word; a new event beats the clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_pend <= '0;
			prev_src <= '0;
		end else begin
			if (tap && ct == CH_RD && ph == PH_C) begin
				int_pend <= next_ev;
				prev_src <= src;
			end else begin
				int_pend <= int_pend | next_ev;
			end
		end
	end

	// Pin synchronisers; third stage feeds the velocity edge detector
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ext_m <= '0;
			ext_s <= '0;
			vp_m <= '0;
			vp_s <= '0;
			vp_d <= '0;
			vu_m <= '0;
			vu_s <= '0;
		end else begin
			ext_m <= ext_irq;
			ext_s <= ext_m;
			vp_m <= vel_pulse;
			vp_s <= vp_m;
			vp_d <= vp_s;
			vu_m <= vel_up;
			vu_s <= vu_m;
		end
	end

	// Velocity counts gathered between taps; width limits burst between passes
	generate
		for (genvar s = 0; s < VEL_SENS; s++) begin : g_vel
			logic signed [VEL_PEND_W-1:0] step;
			logic taken;
			assign step = (vp_s[s] && !vp_d[s]) ? (vu_s[s] ? 4'sh1 : -4'sh1) : 4'sh0;
			assign taken = tap && ct == CH_Y && ph == ((s < NUM_LINES) ? PH_B : PH_C);
			always_ff @(posedge clk) begin
				if (!rstn) begin
					vel_pend[s] <= '0;
				end else if (taken) begin
					vel_pend[s] <= step;
				end else begin
					vel_pend[s] <= vel_pend[s] + step;
				end
			end
		end
	endgenerate

	// Link answers and interrupt line
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.done <= 1'b0;
			link.err <= 1'b0;
			link.rdata <= '0;
			link.irq <= 1'b0;
			rt_latch <= '0;
			dac_tick <= 1'b0;
		end else begin
			link.done <= hit;
			link.err <= link.req && bad && !link.err;
			link.irq <= |((st_v & ~inh_v) & WORD_BITS'({NUM_SLOTS{1'b1}}));
			dac_tick <= tap && next_ev[PEND_DAC];
			if (tap && ct == CH_Y && ph == PH_A) begin
				rt_latch <= cur_v;
			end
			if (hit && !link.wr) begin
				if (ct == CH_Y) begin
					link.rdata <= is_rt_rd ? rt_latch : dl[link.line][ct][ph];
				end else if (ct == CH_RD) begin
					link.rdata <= cur_v;
				end else begin
					link.rdata <= cur_v & REV_MASK;
				end
			end
		end
	end
endmodule : dlis_device

/* File: core/dlis_host.sv */
// Purpose: computer end; turns register commands into link transfers
// Assumes: same clock as the device end
// Notes: a command written while busy is dropped
module dlis_host (
	input wire logic clk,
	input wire logic rstn,
	dlis_link_if.host link,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq
);
	import dlis_pkg::*;

	logic [WORD_BITS-1:0] wbuf;
	logic [WORD_BITS-1:0] rbuf;
	logic busy;
	logic err;

	// Write data buffer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wbuf <= '0;
		end else if (wr && addr == HREG_WDATA) begin
			wbuf <= wdata[WORD_BITS-1:0];
		end
	end

	// Transfer request held until the device answers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.req <= 1'b0;
			link.wr <= 1'b0;
			link.ch <= CH_RD;
			link.ph <= PH_B;
			link.line <= '0;
			link.wdata <= '0;
			busy <= 1'b0;
			err <= 1'b0;
			rbuf <= '0;
		end else if (busy) begin
			if (link.done || link.err) begin
				link.req <= 1'b0;
				busy <= 1'b0;
				err <= link.err;
				if (link.done && !link.wr) begin
					rbuf <= link.rdata;
				end
			end
		end else if (wr && addr == HREG_CMD) begin
			link.req <= 1'b1;
			link.wr <= wdata[CMD_WR];
			link.ch <= wdata[CMD_CH+1:CMD_CH];
			link.ph <= wdata[CMD_PH+1:CMD_PH];
			link.line <= wdata[CMD_LN+1:CMD_LN];
			link.wdata <= wbuf;
			busy <= 1'b1;
			err <= 1'b0;
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= '0;
			irq <= 1'b0;
		end else begin
			irq <= link.irq;
			if (rd) begin
				case (addr)
					HREG_WDATA: rdata <= 32'(wbuf);
					HREG_STAT: begin
						rdata <= '0;
						rdata[ST_BUSY] <= busy;
						rdata[ST_ERR] <= err;
						rdata[ST_IRQ] <= link.irq;
					end
					HREG_RDATA: rdata <= 32'(rbuf);
					default: rdata <= '0;
				endcase
			end else begin
				rdata <= '0;
			end
		end
	end
endmodule : dlis_host

/* File: verification/dlis_assertions.sv */
// Purpose: concurrent checks on the link between the computer end and the adapter end
// Assumes: one clock; rstn synchronous, active low
// Notes: sees link signals only, so source pins are judged by the bench
module dlis_assertions
	import dlis_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic req,
	input wire logic wr,
	input wire logic [1:0] ch,
	input wire logic [1:0] ph,
	input wire logic [1:0] line,
	input wire logic [13:0] wdata,
	input wire logic done,
	input wire logic err,
	input wire logic [13:0] rdata,
	input wire logic irq
);
	int wait_cnt;
	int mute_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Cycles a request has waited; past one circulation a tap was missed
	always_ff @(posedge clk) begin
		if (!rstn || !req || done || err)
			wait_cnt <= 0;
		else
			wait_cnt <= wait_cnt + 1;
	end

	// Cycles since all slots were inhibited; irq is only updated once a pass
	always_ff @(posedge clk) begin
		if (!rstn)
			mute_cnt <= 0;
		else if (done && wr && ch == CH_X && ph == PH_C)
			mute_cnt <= (&wdata[11:0]) ? 1 : 0;
		else if (mute_cnt != 0 && mute_cnt < 9000)
			mute_cnt <= mute_cnt + 1;
	end

	// Refusal pulse follows the request within a few cycles
	sequence s_refuse;
		##[1:3] err;
	endsequence
	// Requester lets go the cycle after the answer
	sequence s_release;
		##1 !req;
	endsequence

	chk_phase_a_refused: assert property ($rose(req) && ph == PH_A && !(ch == CH_Y && !wr) |-> s_refuse)
		else $error("phase A request not refused");
	chk_bad_phase: assert property ($rose(req) && ph == 2'h3 |-> s_refuse)
		else $error("phase 3 request not refused");
	chk_ch4_write: assert property ($rose(req) && wr && ch == CH_Y |-> s_refuse)
		else $error("write to read channel not refused");
	chk_answer_bound: assert property (wait_cnt < 4110)
		else $error("request waited beyond one circulation");
	chk_done_single: assert property (done |=> !done && !err)
		else $error("answer pulse too long");
	chk_req_held: assert property (req && !done && !err |=> req && $stable({wr, ch, ph, line, wdata}))
		else $error("request changed before answer");
	chk_req_release: assert property (done || err |-> s_release)
		else $error("request not released");
	chk_rdata_source: assert property ($changed(rdata) |-> done && !wr)
		else $error("read word changed outside a read");
	chk_narrow_read: assert property (done && !wr && (ch == CH_WR || ch == CH_X) |-> rdata[13:3] == 11'h0)
		else $error("write channel read too wide");
	chk_inhibit_mute: assert property (mute_cnt >= 9000 |-> !irq)
		else $error("inhibited slot still interrupts");
endmodule : dlis_assertions

/* File: verification/delay_line_interrupt_store_tb.sv */
// Purpose: both ends joined; register port, source pins and dac tick checked
// Assumes: 50 MHz clock; waits of 9000 cycles exceed two circulations
// Notes: register reads are queued and compared by the monitor
module delay_line_interrupt_store_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dlis_pkg::*;
	typedef struct {logic [31:0] exp; logic [31:0] mask;} dlis_note_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_q = 1'b0;
	logic [31:0] last_rd = 32'h0;
	logic [31:0] rdata;
	logic irq;
	logic [8:0] ext_irq = 9'h0;
	logic [5:0] vel_pulse = 6'h0;
	logic [5:0] vel_up = 6'h0;
	logic dac_tick;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int last_tick = -1;
	dlis_note_t rd_notes[$];
	logic err_notes[$];
	logic [6:0] bad_req[4] = '{{1'b0, CH_WR, PH_A, 2'h0}, {1'b0, CH_RD, 2'h3, 2'h0},
		{1'b1, CH_Y, PH_B, 2'h0}, {1'b0, CH_Y, PH_B, 2'h3}};

	dlis_link_if link();
	dlis_device dlis_device_inst (.clk(clk), .rstn(rstn), .link(link.dev), .ext_irq(ext_irq),
		.vel_pulse(vel_pulse), .vel_up(vel_up), .dac_tick(dac_tick));
	dlis_host dlis_host_inst (.clk(clk), .rstn(rstn), .link(link.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	dlis_assertions dlis_assertions_inst (.clk(clk), .rstn(rstn), .req(link.req), .wr(link.wr),
		.ch(link.ch), .ph(link.ph), .line(link.line), .wdata(link.wdata), .done(link.done),
		.err(link.err), .rdata(link.rdata), .irq(link.irq));

	// 20 ns clock
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp_flag

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		rd_notes.push_back('{e, m});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask : reg_rd

	// One link transfer; waits for the answer, then three more cycles
	task automatic xfer(input logic w, input logic [1:0] c, input logic [1:0] p,
		input logic [1:0] l, input logic [13:0] d, input logic e);
		int n;
		err_notes.push_back(e);
		reg_wr(HREG_WDATA, {18'h0, d});
		reg_wr(HREG_CMD, {25'h0, l, p, c, w});
		n = 0;
		while (!(link.done || link.err) && n < 5000) begin
			@(posedge clk);
			n++;
		end
		cmp_flag(n < 5000, 1'b1);
		repeat (3) @(posedge clk);
	endtask : xfer

	task automatic rdw(input logic [1:0] c, input logic [1:0] p, input logic [1:0] l,
		input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, c, p, l, 14'h0, 1'b0);
		reg_rd(HREG_RDATA, e, m);
	endtask : rdw

	// Monitor: read answers, refusals and the dac tick spacing
	always @(posedge clk) begin
		dlis_note_t n;
		if (rd_q) begin
			n = rd_notes.pop_front();
			cmp_word(rdata & n.mask, n.exp & n.mask);
			last_rd <= rdata;
		end
		if (link.done || link.err)
			cmp_flag(link.err, err_notes.pop_front());
		if (dac_tick) begin
			if (last_tick >= 0)
				cmp_flag((cyc - last_tick) inside {[41000:41030]}, 1'b1);
			last_tick <= cyc;
		end
		rd_q <= rd;
		cyc <= cyc + 1;
	end

	// Hang guard, well above the expected run length
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		$display("timeout at %0t", $time);
		close_out();
	end

	initial begin
		int k;
		int n;
		int m;
		longint rt_est;
		k = $urandom(56563);
		k = $urandom_range(8, 0);
		n = $urandom_range(7, 1);
		m = $urandom_range(7, 1);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		// Source held far longer than one pass; countdown armed with one step
		ext_irq <= 9'(1 << k);
		vel_up <= 6'h01;
		xfer(1'b1, CH_WR, PH_B, 2'h0, 14'h0001, 1'b0);
		for (int i = 0; i < 7; i++) begin
			vel_pulse <= {i < m, 4'h0, i < n};
			repeat (20) @(posedge clk);
			vel_pulse <= 6'h0;
			repeat (20) @(posedge clk);
		end
		repeat (9000) @(posedge clk);
		rdw(CH_RD, PH_C, 2'h0, 32'(1 << k), 32'h1ff);
		reg_rd(HREG_STAT, 32'h4, 32'h4);
		cmp_flag(irq, 1'b1);
		rdw(CH_Y, PH_B, 2'h0, 32'(n), 32'h3fff);
		rdw(CH_Y, PH_C, 2'h2, 32'(-m), 32'h3fff);
		rdw(CH_Y, PH_C, 2'h0, 32'h0, 32'h3fff);
		// Inhibit every slot: storage kept, line quiet
		xfer(1'b1, CH_X, PH_C, 2'h0, 14'h3fff, 1'b0);
		rdw(CH_X, PH_C, 2'h0, 32'h7, 32'h3fff);
		repeat (9000) @(posedge clk);
		reg_rd(HREG_STAT, 32'h0, 32'h4);
		cmp_flag(irq, 1'b0);
		rdw(CH_RD, PH_C, 2'h0, 32'(1 << k), 32'h1ff);
		// Clear while the source is still high: no new store until it returns
		xfer(1'b1, CH_RD, PH_C, 2'h0, 14'h01ff, 1'b0);
		repeat (9000) @(posedge clk);
		rdw(CH_RD, PH_C, 2'h0, 32'h0, 32'h1ff);
		ext_irq <= 9'h0;
		// One pass plus the pin chain is enough to see the source low
		repeat (4500) @(posedge clk);
		ext_irq <= 9'(1 << k);
		repeat (9000) @(posedge clk);
		rdw(CH_RD, PH_C, 2'h0, 32'(1 << k), 32'h1ff);
		// Real time asked for at phase A; the answer lags by up to one pass plus a step
		xfer(1'b0, CH_Y, PH_A, 2'h0, 14'h0, 1'b0);
		reg_rd(HREG_RDATA, 32'h0, 32'hffffc000);
		repeat (2) @(posedge clk);
		rt_est = longint'(cyc) * (1000000000 / CLK_HZ) / RT_STEP_NS;
		cmp_flag(longint'(last_rd) inside {[rt_est - 1:rt_est]}, 1'b1);
		// Refused requests
		foreach (bad_req[i])
			xfer(bad_req[i][6], bad_req[i][5:4], bad_req[i][3:2], bad_req[i][1:0], 14'h0, 1'b1);
		rdw(CH_RD, PH_C, 2'h0, 32'h200, 32'h600);
		close_out();
	end
endmodule : delay_line_interrupt_store_tb
